// ==== common/pwm_prot_consts.vh ====
`ifndef PWM_PROT_CONSTS_VH
`define PWM_PROT_CONSTS_VH
// register offsets (byte addresses)
`define OFS_CTRL        8'h00
`define OFS_OVR         8'h04
`define OFS_FAULT_CTRL  8'h08
`define OFS_FAULT_STAT  8'h0C
`define OFS_FAULT_ACK   8'h10
`define OFS_DISABLE_MAP_REGISTER      8'h14
`define OFS_MODULUS     8'h18
`define OFS_DEADTIME    8'h1C
`define OFS_STATUS      8'h20
// control register fields
`define CTL_EN          0
`define CTL_LOAD        1
`define CTL_RLDF        2
`define CTL_RLDIE       3
`define CTL_BANK_X_SOFT_DISABLE        4
`define CTL_BANK_Y_SOFT_DISABLE        5
`define CTL_PRSC_LO     6
`define CTL_PRSC_HI     7
`define CTL_OVR_EN      8
`define CTL_COMPL       9
`define CTL_TOPNEG      10
`define CTL_BOTNEG      11
// fault control fields: rearm mode [3:0], interrupt enable [7:4]
`define FC_MODE_LO      0
`define FC_INT_LO       4
// reset values
`define RST_DISABLE_MAP_REGISTER      12'hFFF
`define RST_MODULUS     12'h000
`define RST_DEADTIME    8'h00
// timing
`define CLK_PERIOD_NS   10
`define FILT_SAMPLES    2
`endif

// ==== core/dead_time_gen.v ====
`default_nettype none
// one complementary pair: inserts dead time on each toggle of the top request
module dead_time_gen (
  input  wire       clk_sys,
  input  wire       sys_rst,
  input  wire       top_req,
  input  wire [7:0] dead_cycles,
  output wire       top_act,
  output wire       bot_act
);
  reg       last_q;
  reg [7:0] cnt_q;

  // restart the gap counter on every edge of the request
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      last_q <= 1'b0;
      cnt_q  <= 8'h00;
    end else begin
      last_q <= top_req;
      if (top_req != last_q)
        cnt_q <= dead_cycles;
      else if (cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
    end
  end

  // both sides off while the gap runs, so the pair never overlaps
  assign top_act = (cnt_q == 8'h00) && last_q && top_req;
  assign bot_act = (cnt_q == 8'h00) && !last_q && !top_req;
endmodule
`default_nettype wire

// ==== core/pwm_output_protect.v ====
// Contract
// - override bits drive pins when enabled
// - polarity, interlock, dead time kept in override
// - even override bits feed dead time
// - generator keeps running; override without enable
// - leaving override waits for cycle start or disable
// - faults or soft disable force inactive
// - two banks mapped through disable map
// - full map disables all six outputs
// - per-fault automatic or manual rearm
// - low arm, two high samples filter
// - automatic rearm needs low plus cycle
// - level mirrors pin; flag cleared by ack
// - per-fault interrupt latch and clears
// - manual rearm; faults 2,4 need low
// - soft disable releases at cycle start
// - override rearms every clock
// - first enable reloads, sets flag
// - no load permit keeps previous modulus
// - pins drive after prescale dependent delay
// - disable tri-states, clears counter
// - disable keeps flag and interrupts
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`include "pwm_prot_consts.vh"
`default_nettype none
module pwm_output_protect (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire [5:0]  gen_pwm,
  input  wire [3:0]  fault_in,
  output reg  [5:0]  pwm_out,
  output reg  [5:0]  pwm_oe,
  output reg  [3:0]  fault_irq,
  output reg         reload_irq,
  output reg         cycle_start
);
  // control and configuration
  reg        en_q;
  reg        rldf_q;
  reg        rldie_q;
  reg        bank_x_soft_disable_q;
  reg        bank_y_soft_disable_q;
  reg        ovr_en_q;
  reg        compl_q;
  reg        topneg_q;
  reg        botneg_q;
  reg [1:0]  prsc_q;
  reg        load_q;
  reg [5:0]  ovr_q;
  reg [3:0]  fmode_q;
  reg [3:0]  fint_q;
  reg [11:0] disable_map_register_q;
  reg        disable_map_register_done_q;
  reg [11:0] mod_buf_q;
  reg [11:0] mod_act_q;
  reg [7:0]  dead_q;
  reg        ovr_src_q;
  reg [11:0] cnt_q;
  reg [1:0]  pre_q;
  reg        hiz_q;
  // fault state
  reg [3:0]  armed_q;
  reg [3:0]  samp_q;
  reg [3:0]  flev_q;
  reg [3:0]  fflag_q;
  reg [3:0]  fdis_q;
  reg        sdx_q;
  reg        sdy_q;
  integer    i;

  wire wr_ctl = reg_wr && reg_addr == `OFS_CTRL;
  wire wr_ack = reg_wr && reg_addr == `OFS_FAULT_ACK;
  wire en_set = wr_ctl && reg_wdata[`CTL_EN] && !en_q;
  wire wrap   = en_q && cnt_q >= mod_act_q && pre_q == 2'b00;
  // with override on, clearing runs each clock instead of waiting for a wrap
  wire rearm  = ovr_src_q ? 1'b1 : wrap;
  wire [3:0] ack = wr_ack ? reg_wdata[3:0] : 4'h0;
  wire [3:0] rise;

  // per-pin filter and latches
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : flt
      // arm on one low sample, then need two high samples
      assign rise[g] = armed_q[g] && samp_q[g] && fault_in[g];
      always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          armed_q[g] <= 1'b0;
          samp_q[g]  <= 1'b0;
          flev_q[g]  <= 1'b0;
          fflag_q[g] <= 1'b0;
          fdis_q[g]  <= 1'b0;
          fault_irq[g] <= 1'b0;
        end else begin
          samp_q[g] <= fault_in[g] && armed_q[g];
          if (!fault_in[g]) begin
            armed_q[g] <= 1'b1;
            flev_q[g]  <= 1'b0;
          end else if (rise[g]) begin
            armed_q[g] <= 1'b0;
            flev_q[g]  <= 1'b1;
          end
          // set wins over acknowledge
          if (rise[g])
            fflag_q[g] <= 1'b1;
          else if (ack[g])
            fflag_q[g] <= 1'b0;
          if (rise[g] && fint_q[g])
            fault_irq[g] <= 1'b1;
          else if (ack[g] || !fint_q[g])
            fault_irq[g] <= 1'b0;
          // disable at once; release only at a rearm point
          if (rise[g]) begin
            fdis_q[g] <= 1'b1;
          end else if (rearm && fdis_q[g]) begin
            // automatic follows the filtered level; manual waits for the ack
            if (fmode_q[g])
              fdis_q[g] <= flev_q[g];
            else if (g == 0 || g == 2)
              fdis_q[g] <= fflag_q[g] && !ack[g];
            else
              // inputs 2 and 4 also need the pin low at release
              fdis_q[g] <= (fflag_q[g] && !ack[g]) || fault_in[g];
          end
        end
      end
    end
  endgenerate

  // bank disable; each map bit pair chooses bank per pin
  // a soft disable stays in force through sdx/sdy until the next rearm
  wire bank_x = (|fdis_q[1:0]) || bank_x_soft_disable_q || sdx_q;
  wire bank_y = (|fdis_q[3:2]) || bank_y_soft_disable_q || sdy_q;
  wire [5:0] kill;
  generate
    for (g = 0; g < 6; g = g + 1) begin : map
      assign kill[g] = (disable_map_register_q[2*g] & bank_x) | (disable_map_register_q[2*g+1] & bank_y);
    end
  endgenerate

  // override source with complementary partner; generator runs regardless
  wire [5:0] src = ovr_src_q ? ovr_q : (en_q ? gen_pwm : 6'h00);
  wire [5:0] act;
  generate
    for (g = 0; g < 3; g = g + 1) begin : pair
      wire t_a, b_a;
      // even bits drive the dead time generator, odd bits only gate
      dead_time_gen dead_time_gen_inst (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .top_req     (src[2*g]),
        .dead_cycles (dead_q),
        .top_act     (t_a),
        .bot_act     (b_a)
      );
      assign act[2*g]   = compl_q ? t_a : src[2*g];
      assign act[2*g+1] = compl_q ? (b_a && src[2*g+1]) : src[2*g+1];
    end
  endgenerate

  // soft disables hold until a rearm point after clearing
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sdx_q <= 1'b0;
      sdy_q <= 1'b0;
    end else begin
      sdx_q <= bank_x_soft_disable_q || (sdx_q && !rearm);
      sdy_q <= bank_y_soft_disable_q || (sdy_q && !rearm);
    end
  end

  // control word; load permit is write-only and lives with the reload logic
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      en_q     <= 1'b0;
      rldie_q  <= 1'b0;
      bank_x_soft_disable_q   <= 1'b0;
      bank_y_soft_disable_q   <= 1'b0;
      prsc_q   <= 2'b00;
      ovr_en_q <= 1'b0;
      compl_q  <= 1'b0;
      topneg_q <= 1'b0;
      botneg_q <= 1'b0;
    end else if (wr_ctl) begin
      en_q     <= reg_wdata[`CTL_EN];
      rldie_q  <= reg_wdata[`CTL_RLDIE];
      bank_x_soft_disable_q   <= reg_wdata[`CTL_BANK_X_SOFT_DISABLE];
      bank_y_soft_disable_q   <= reg_wdata[`CTL_BANK_Y_SOFT_DISABLE];
      prsc_q   <= reg_wdata[`CTL_PRSC_HI:`CTL_PRSC_LO];
      ovr_en_q <= reg_wdata[`CTL_OVR_EN];
      compl_q  <= reg_wdata[`CTL_COMPL];
      topneg_q <= reg_wdata[`CTL_TOPNEG];
      botneg_q <= reg_wdata[`CTL_BOTNEG];
    end
  end

  // override bits, fault setup, modulus buffer and dead time
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ovr_q     <= 6'h00;
      fmode_q   <= 4'h0;
      fint_q    <= 4'h0;
      mod_buf_q <= `RST_MODULUS;
      dead_q    <= `RST_DEADTIME;
    end else begin
      if (reg_wr && reg_addr == `OFS_OVR)
        ovr_q <= reg_wdata[5:0];
      if (reg_wr && reg_addr == `OFS_FAULT_CTRL) begin
        fmode_q <= reg_wdata[`FC_MODE_LO+3:`FC_MODE_LO];
        fint_q  <= reg_wdata[`FC_INT_LO+3:`FC_INT_LO];
      end
      if (reg_wr && reg_addr == `OFS_MODULUS)
        mod_buf_q <= reg_wdata[11:0];
      // a late change can disturb one gap; software sets it before enabling
      if (reg_wr && reg_addr == `OFS_DEADTIME)
        dead_q <= reg_wdata[7:0];
    end
  end

  // map is write-once to protect the power stage
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      disable_map_register_q      <= `RST_DISABLE_MAP_REGISTER;
      disable_map_register_done_q <= 1'b0;
    end else if (reg_wr && reg_addr == `OFS_DISABLE_MAP_REGISTER && !disable_map_register_done_q) begin
      disable_map_register_q      <= reg_wdata[11:0];
      disable_map_register_done_q <= 1'b1;
    end
  end

  // entering override is at once, leaving waits for a cycle start or is at once when disabled
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      ovr_src_q <= 1'b0;
    else if (ovr_en_q)
      ovr_src_q <= 1'b1;
    else if (!en_q || wrap)
      ovr_src_q <= 1'b0;
  end

  // counter stops and clears while disabled
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 12'h000;
      pre_q <= 2'b00;
    end else if (!en_q || en_set) begin
      cnt_q <= 12'h000;
      pre_q <= 2'b00;
    end else if (pre_q != prsc_q) begin
      pre_q <= pre_q + 2'b01;
    end else begin
      pre_q <= 2'b00;
      cnt_q <= wrap ? 12'h000 : cnt_q + 12'h001;
    end
  end

  // reload at first enable and each wrap; old modulus kept without permit
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rldf_q    <= 1'b0;
      load_q    <= 1'b0;
      mod_act_q <= `RST_MODULUS;
    end else begin
      if (en_set || wrap)
        rldf_q <= 1'b1;
      else if (wr_ctl && !reg_wdata[`CTL_RLDF])
        rldf_q <= 1'b0;
      if ((en_set || wrap) && load_q) begin
        mod_act_q <= mod_buf_q;
        load_q    <= 1'b0;
      end else if (wr_ctl && reg_wdata[`CTL_LOAD])
        load_q <= 1'b1;
    end
  end

  // interrupt level and cycle marker; the flag survives a disable
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reload_irq  <= 1'b0;
      cycle_start <= 1'b0;
    end else begin
      reload_irq  <= rldie_q && (rldf_q || en_set);
      cycle_start <= en_set || wrap;
    end
  end

  // pins wait a full cycle unless prescale is zero
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      hiz_q <= 1'b1;
    else if (en_set && reg_wdata[`CTL_PRSC_HI:`CTL_PRSC_LO] == 2'b00)
      hiz_q <= 1'b0;
    else if (!en_q)
      hiz_q <= 1'b1;
    else if (wrap)
      hiz_q <= 1'b0;
  end

  // inactive level per pin: top pins even, bottom pins odd
  wire [5:0] inact = {3{botneg_q, topneg_q}};

  // output stage: kill forces inactive, then polarity per top/bottom
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_out <= 6'h00;
      pwm_oe  <= 6'h00;
    end else begin
      for (i = 0; i < 6; i = i + 1) begin
        pwm_out[i] <= (act[i] && !kill[i]) ^ inact[i];
        pwm_oe[i]  <= ovr_src_q || (en_q && !hiz_q);
      end
    end
  end

  // read port, data one cycle after the strobe
  // load permit is write-only, so bit 1 of the control word reads zero
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd) begin
      case (reg_addr)
        `OFS_CTRL:       reg_rdata <= {20'h00000, botneg_q, topneg_q, compl_q, ovr_en_q,
                                       prsc_q, bank_y_soft_disable_q, bank_x_soft_disable_q, rldie_q, rldf_q, 1'b0, en_q};
        `OFS_OVR:        reg_rdata <= {26'h0000000, ovr_q};
        `OFS_FAULT_CTRL: reg_rdata <= {24'h000000, fint_q, fmode_q};
        `OFS_FAULT_STAT: reg_rdata <= {24'h000000, fflag_q, flev_q};
        `OFS_DISABLE_MAP_REGISTER:     reg_rdata <= {20'h00000, disable_map_register_q};
        `OFS_MODULUS:    reg_rdata <= {20'h00000, mod_buf_q};
        `OFS_DEADTIME:   reg_rdata <= {24'h000000, dead_q};
        `OFS_STATUS:     reg_rdata <= {26'h0000000, kill};
        default:         reg_rdata <= 32'h00000000;
      endcase
    end else
      reg_rdata <= 32'h00000000;
  end
endmodule
`default_nettype wire

// ==== verification/power_stage_model.sv ====
`default_nettype none
module power_stage_model (
  input  wire logic       clk_sys,
  input  wire logic [3:0] fault_req,
  input  wire logic [5:0] pwm_out,
  input  wire logic [5:0] pwm_oe,
  output var  logic [3:0] fault_in = 4'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // sensor comparators are clocked, so a trip shows one cycle late
  always @(posedge clk_sys)
    fault_in <= fault_req;
endmodule
`default_nettype wire

// ==== verification/pwm_output_protect_chk.sv ====
`include "pwm_prot_consts.vh"
`default_nettype none
module pwm_output_protect_chk (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic [3:0]  fault_in,
  input wire logic [5:0]  pwm_out,
  input wire logic [5:0]  pwm_oe,
  input wire logic [3:0]  fault_irq,
  input wire logic        reload_irq,
  input wire logic        cycle_start
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] ctl_q;
  wire         cw = reg_wr && reg_addr == `OFS_CTRL;
  wire [5:0]   inact = {3{ctl_q[11], ctl_q[10]}};
  wire [5:0]   act = pwm_out ^ inact;
  // shadow of the control word: polarity and enables are not visible otherwise
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      ctl_q <= 12'h000;
    else if (cw)
      ctl_q <= reg_wdata[11:0];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_fault_kill:
    assert property (!fault_in[1] ##1 fault_in[1] [*2] |-> ##[1:2] pwm_out == inact)
    else $error("fault did not force pins inactive");
  chk_pair_apart:
    assert property (ctl_q[9] |-> (act[5:1] & act[4:0] & 5'h15) == 5'h00)
    else $error("both pins of a pair active");
  chk_ack_irq:
    assert property (reg_wr && reg_addr == `OFS_FAULT_ACK && reg_wdata[1] && !fault_in[1]
      |=> !fault_irq[1]) else $error("ack left fault irq set");
  chk_irq_off:
    assert property (reg_wr && reg_addr == `OFS_FAULT_CTRL && !reg_wdata[5] && !fault_in[1]
      |-> ##2 !fault_irq[1]) else $error("disable left fault irq set");
  chk_irq_cause:
    assert property ($rose(fault_irq[1]) |-> $past(fault_in[1]))
    else $error("fault irq without fault");
  chk_reload_keep:
    assert property (reload_irq && cw && reg_wdata[2] && reg_wdata[3] |=> reload_irq)
    else $error("reload irq lost");
  chk_first_reload:
    assert property (cw && reg_wdata[0] && !ctl_q[0] |-> ##[1:2] cycle_start)
    else $error("no reload on enable");
  chk_pins_float:
    assert property ((!ctl_q[0] && !ctl_q[8]) [*3] |-> pwm_oe == 6'h00)
    else $error("pins driven while off");
  chk_pins_drive:
    assert property (cw && reg_wdata[0] && reg_wdata[7:6] == 2'b00 && !ctl_q[0]
      |-> ##[1:3] pwm_oe == 6'h3F) else $error("pins not driven after enable");
endmodule
bind pwm_output_protect pwm_output_protect_chk pwm_output_protect_chk_inst (.*);
`default_nettype wire

// ==== verification/test_pwm_output_protect.sv ====
`include "pwm_prot_consts.vh"
`default_nettype none
module test_pwm_output_protect;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [5:0]  gen_pwm = 6'h00, pwm_out, pwm_oe;
  logic [3:0]  fault_req = 4'h0, fault_in, fault_irq;
  logic        reload_irq, cycle_start;
  int          bad_count = 0, n_checks = 0, cyc = 0;
  pwm_output_protect pwm_output_protect_inst (.*);
  power_stage_model power_stage_model_inst (.*);
  always #5 clk_sys = ~clk_sys;
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // a hung wait ends the run as a failure
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // strobe released a full cycle before the next request
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata & m, e);
    @(posedge clk_sys);
  endtask
  // pins sampled at the falling edge where they have settled
  task automatic po(input logic [5:0] e, input logic [5:0] oe);
    @(negedge clk_sys);
    for (int i = 0; i < 16 && {pwm_oe, pwm_out} !== {oe, e}; i++) @(negedge clk_sys);
    chk(32'({pwm_oe, pwm_out}), 32'({oe, e}));
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rc(`OFS_DISABLE_MAP_REGISTER, 32'hFFF, 32'hFFF);
    rc(8'h30, 32'hFFFFFFFF, 32'h0);
    wr(`OFS_CTRL, 32'h00B);
    po(6'h00, 6'h3F);
    rc(`OFS_CTRL, 32'h4, 32'h4);
    wr(`OFS_CTRL, 32'h00C);
    po(6'h00, 6'h00);
    chk(32'(reload_irq), 32'h1);
    wr(`OFS_OVR, 32'h00);
    wr(`OFS_CTRL, 32'h100);
    wr(`OFS_OVR, 32'h15);
    po(6'h15, 6'h3F);
    wr(`OFS_CTRL, 32'h500);
    po(6'h00, 6'h3F);
    wr(`OFS_CTRL, 32'h100);
    wr(`OFS_FAULT_CTRL, 32'h20);
    // a one-cycle glitch must be filtered out
    fault_req <= 4'h2;
    @(posedge clk_sys);
    fault_req <= 4'h0;
    repeat (4) @(posedge clk_sys);
    rc(`OFS_FAULT_STAT, 32'hFF, 32'h00);
    fault_req <= 4'h2;
    po(6'h00, 6'h3F);
    rc(`OFS_FAULT_STAT, 32'hFF, 32'h22);
    chk(32'(fault_irq), 32'h2);
    wr(`OFS_FAULT_ACK, 32'h2);
    rc(`OFS_FAULT_STAT, 32'hFF, 32'h02);
    chk(32'({fault_irq, pwm_out}), 32'h000);
    fault_req <= 4'h0;
    po(6'h15, 6'h3F);
    wr(`OFS_FAULT_CTRL, 32'h02);
    fault_req <= 4'h2;
    po(6'h00, 6'h3F);
    fault_req <= 4'h0;
    po(6'h15, 6'h3F);
    wr(`OFS_CTRL, 32'h110);
    po(6'h00, 6'h3F);
    wr(`OFS_CTRL, 32'h100);
    po(6'h15, 6'h3F);
    wr(`OFS_DISABLE_MAP_REGISTER, 32'h555);
    wr(`OFS_DISABLE_MAP_REGISTER, 32'h000);
    rc(`OFS_DISABLE_MAP_REGISTER, 32'hFFF, 32'h555);
    wr(`OFS_CTRL, 32'h120);
    po(6'h15, 6'h3F);
    wr(`OFS_OVR, 32'h00);
    wr(`OFS_CTRL, 32'h300);
    wr(`OFS_OVR, 32'h03);
    po(6'h01, 6'h3F);
    wr(`OFS_OVR, 32'h02);
    po(6'h02, 6'h3F);
    wr(`OFS_OVR, 32'h00);
    wr(`OFS_CTRL, 32'h001);
    po(6'h00, 6'h3F);
    gen_pwm <= 6'h15;
    po(6'h15, 6'h3F);
    wr(`OFS_CTRL, 32'h000);
    po(6'h00, 6'h00);
    wr(`OFS_CTRL, 32'h041);
    po(6'h15, 6'h3F);
    complete_run();
  end
endmodule
`default_nettype wire
